// *** design/cpusr_addr_map.v ***
`timescale 1ns/10ps
`include "cpusr_regs.vh"
// combinational address former for banked registers and direct page
module cpusr_addr_map (
    input  wire [4:0]  bank_i,
    input  wire [2:0]  page_i,
    input  wire [2:0]  reg_sel_i,
    input  wire [7:0]  dir_addr_i,
    output wire [15:0] greg_addr_o,
    output wire [15:0] dir_phys_o
);
    // high byte fixed, bank on a7..a3, opcode bits on a2..a0
    assign greg_addr_o = {`CPUSR_GREG_HIGH, bank_i, reg_sel_i};

    // page n>0 places the upper half at 0080h + n*80h
    wire [15:0] paged = `CPUSR_DIR_PAGE_BASE
                      + {6'h00, page_i, 7'h00}
                      + {9'h000, dir_addr_i[6:0]};
    assign dir_phys_o = (!dir_addr_i[7] || page_i == 3'h0)
                      ? {8'h00, dir_addr_i}
                      : paged;
endmodule

// *** design/cpusr_core_regs.v ***
`timescale 1ns/10ps
`include "cpusr_regs.vh"
// Behaviour
// - one 64-Kbyte space; all formed addresses are 16 bits wide
// - instruction address counter is 16 bits, holds fetch location
// - accumulator 16 bits; 8-bit work uses only low byte
// - temporary accumulator 16 bits, second ALU operand, low byte in 8-bit
// - 16-bit index register modifies operand addresses
// - 16-bit extra pointer selects memory location for pointer access
// - 16-bit stack pointer marks current stack area
// - status word: bank and page pointers high byte, flags low byte
// - register address is 01h, bank on A7..A3, opcode bits A2..A0
// - direct 80h..FFh remapped by page pointer; zero leaves unmapped
// - direct 00h..7Fh always unmapped
// - half carry on carry or borrow between bits 3 and 4
// - interrupt enable flag gates interrupts, cleared by reset
// - interrupt taken only if request level outranks current level
// - negative flag copies result msb
// - zero flag set when result is zero
// - overflow flag set on two's complement overflow
// - carry on carry/borrow out of bit 7 (bit 15 in 16-bit work); shifts load shifted-out bit
// - eight 8-bit registers per bank, up to 32 banks
// - bank and page pointers also reachable through mirror at 0078h
module cpusr_core_regs (
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // sequencer side
    input  wire        pc_load_i,
    input  wire        pc_inc_i,
    input  wire [15:0] pc_val_i,
    input  wire        acc_load_i,
    input  wire        tacc_load_i,
    input  wire        acc_to_tacc_i,
    input  wire        ix_load_i,
    input  wire        ep_load_i,
    input  wire        sp_load_i,
    input  wire [15:0] load_val_i,
    input  wire        alu_go_i,
    input  wire [2:0]  alu_op_i,
    input  wire        alu_wide_i,
    input  wire        ps_hi_load_i,
    input  wire        ccr_load_i,
    input  wire [7:0]  ps_val_i,
    input  wire        mem_wr_i,
    input  wire [15:0] mem_addr_i,
    input  wire [7:0]  mem_wdata_i,
    input  wire [2:0]  reg_sel_i,
    input  wire [7:0]  dir_addr_i,
    input  wire        irq_req_i,
    input  wire [1:0]  irq_level_i,
    output reg  [15:0] instr_address_counter_o,
    output reg  [15:0] acc_o,
    output reg  [15:0] tacc_o,
    output reg  [15:0] index_reg_o,
    output reg  [15:0] extra_pointer_o,
    output reg  [15:0] stack_pointer_o,
    output reg  [15:0] program_status_word_o,
    output reg  [15:0] greg_addr_o,
    output reg  [15:0] dir_phys_o,
    output reg         irq_accept_o
);
    reg [15:0] instr_address_counter_reg;
    reg [15:0] acc_reg;
    reg [15:0] tacc_reg;
    reg [15:0] index_reg;
    reg [15:0] extra_pointer_reg;
    reg [15:0] stack_pointer_reg;
    reg [7:0]  psw_hi_reg;
    reg [7:0]  ccr_reg;
    reg        ack_reg;

    wire [15:0] alu_res;
    wire        f_h;
    wire        f_n;
    wire        f_z;
    wire        f_v;
    wire        f_c;
    wire [15:0] greg_addr;
    wire [15:0] dir_phys;

    // the bank pointer is the top five bits, page pointer the next three
    wire [4:0] bank_pointer      = psw_hi_reg[7:3];
    wire [2:0] page_select_bits  = psw_hi_reg[2:0];
    wire [1:0] current_irq_level = ccr_reg[5:4];

    function [15:0] wb_merge;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        begin
            wb_merge = {sel[1] ? dat[15:8] : old[15:8],
                        sel[0] ? dat[7:0]  : old[7:0]};
        end
    endfunction

    cpusr_flag_alu u_alu (
        .op_i    (alu_op_i),
        .wide_i  (alu_wide_i),
        .a_i     (acc_reg),
        .b_i     (tacc_reg),
        .carry_i (ccr_reg[`CPUSR_CCR_C]),
        .res_o   (alu_res),
        .h_o     (f_h),
        .n_o     (f_n),
        .z_o     (f_z),
        .v_o     (f_v),
        .c_o     (f_c)
    );

    cpusr_addr_map u_map (
        .bank_i      (bank_pointer),
        .page_i      (page_select_bits),
        .reg_sel_i   (reg_sel_i),
        .dir_addr_i  (dir_addr_i),
        .greg_addr_o (greg_addr),
        .dir_phys_o  (dir_phys)
    );

    wire wb_req  = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wb_wr   = wb_req && wb_we_i;
    wire wb_lo   = wb_sel_i[0];
    // memory-side write to the mirror byte
    wire mir_wr  = mem_wr_i && (mem_addr_i == `CPUSR_MIRROR_ADDR);

    // reset word split into the two status bytes without losing bits
    localparam [15:0] RST_PSW = `CPUSR_RST_PSW;

    reg [15:0] instr_address_counter_next;
    reg [15:0] acc_next;
    reg [15:0] tacc_next;
    reg [15:0] index_next;
    reg [15:0] extra_pointer_next;
    reg [15:0] stack_pointer_next;
    reg [7:0]  psw_hi_next;
    reg [7:0]  ccr_next;

    // sequencer updates first; a bus write to the same register wins
    always @* begin
        instr_address_counter_next = instr_address_counter_reg;
        acc_next                   = acc_reg;
        tacc_next                  = tacc_reg;
        index_next                 = index_reg;
        extra_pointer_next         = extra_pointer_reg;
        stack_pointer_next         = stack_pointer_reg;
        psw_hi_next                = psw_hi_reg;
        ccr_next                   = ccr_reg;
        if (pc_load_i) begin
            instr_address_counter_next = pc_val_i;
        end else if (pc_inc_i) begin
            instr_address_counter_next = instr_address_counter_reg
                                       + 16'h0001;
        end
        if (acc_to_tacc_i) begin
            tacc_next = acc_reg;
        end else if (tacc_load_i) begin
            tacc_next = load_val_i;
        end
        if (alu_go_i) begin
            acc_next               = alu_res;
            ccr_next[`CPUSR_CCR_H] = f_h;
            ccr_next[`CPUSR_CCR_N] = f_n;
            ccr_next[`CPUSR_CCR_Z] = f_z;
            ccr_next[`CPUSR_CCR_V] = f_v;
            ccr_next[`CPUSR_CCR_C] = f_c;
        end else if (acc_load_i) begin
            acc_next = load_val_i;
        end
        if (ix_load_i) begin
            index_next = load_val_i;
        end
        if (ep_load_i) begin
            extra_pointer_next = load_val_i;
        end
        if (sp_load_i) begin
            stack_pointer_next = load_val_i;
        end
        if (ccr_load_i) begin
            ccr_next = ps_val_i;
        end
        // psw high byte and the mirror share one register
        if (ps_hi_load_i) begin
            psw_hi_next = ps_val_i;
        end else if (mir_wr) begin
            psw_hi_next = mem_wdata_i;
        end
        if (wb_wr) begin
            case (wb_adr_i)
                `CPUSR_OFF_PC: begin
                    instr_address_counter_next =
                        wb_merge(instr_address_counter_reg,
                                 wb_dat_i, wb_sel_i);
                end
                `CPUSR_OFF_ACC: begin
                    acc_next = wb_merge(acc_reg, wb_dat_i, wb_sel_i);
                end
                `CPUSR_OFF_TACC: begin
                    tacc_next = wb_merge(tacc_reg, wb_dat_i, wb_sel_i);
                end
                `CPUSR_OFF_IX: begin
                    index_next = wb_merge(index_reg, wb_dat_i, wb_sel_i);
                end
                `CPUSR_OFF_EP: begin
                    extra_pointer_next = wb_merge(extra_pointer_reg,
                                                  wb_dat_i, wb_sel_i);
                end
                `CPUSR_OFF_SP: begin
                    stack_pointer_next = wb_merge(stack_pointer_reg,
                                                  wb_dat_i, wb_sel_i);
                end
                `CPUSR_OFF_PSW: begin
                    if (wb_sel_i[1]) begin
                        psw_hi_next = wb_dat_i[15:8];
                    end
                    if (wb_lo) begin
                        ccr_next = wb_dat_i[7:0];
                    end
                end
                `CPUSR_OFF_MIRROR: begin
                    if (wb_lo) begin
                        psw_hi_next = wb_dat_i[7:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            instr_address_counter_reg <= `CPUSR_RST_WORD;
            acc_reg                   <= `CPUSR_RST_WORD;
            tacc_reg                  <= `CPUSR_RST_WORD;
            index_reg                 <= `CPUSR_RST_WORD;
            extra_pointer_reg         <= `CPUSR_RST_WORD;
            stack_pointer_reg         <= `CPUSR_RST_WORD;
            psw_hi_reg                <= RST_PSW[15:8];
            ccr_reg                   <= RST_PSW[7:0];
            ack_reg                   <= 1'b0;
        end else begin
            ack_reg                   <= wb_req;
            instr_address_counter_reg <= instr_address_counter_next;
            acc_reg                   <= acc_next;
            tacc_reg                  <= tacc_next;
            index_reg                 <= index_next;
            extra_pointer_reg         <= extra_pointer_next;
            stack_pointer_reg         <= stack_pointer_next;
            psw_hi_reg                <= psw_hi_next;
            ccr_reg                   <= ccr_next;
        end
    end

    // read mux; unmapped offsets read zero and still ack
    reg [31:0] rd_next;
    always @* begin
        rd_next = 32'h00000000;
        case (wb_adr_i)
            `CPUSR_OFF_PC:     rd_next = {16'h0000, instr_address_counter_reg};
            `CPUSR_OFF_ACC:    rd_next = {16'h0000, acc_reg};
            `CPUSR_OFF_TACC:   rd_next = {16'h0000, tacc_reg};
            `CPUSR_OFF_IX:     rd_next = {16'h0000, index_reg};
            `CPUSR_OFF_EP:     rd_next = {16'h0000, extra_pointer_reg};
            `CPUSR_OFF_SP:     rd_next = {16'h0000, stack_pointer_reg};
            `CPUSR_OFF_PSW:    rd_next = {16'h0000, psw_hi_reg, ccr_reg};
            `CPUSR_OFF_MIRROR: rd_next = {24'h000000, psw_hi_reg};
            `CPUSR_OFF_STATUS: rd_next = {greg_addr, dir_phys};
            default:           rd_next = 32'h00000000;
        endcase
    end

    // a level-3 request never outranks the current level, so it never enters
    reg irq_ok;
    always @* begin
        irq_ok = 1'b0;
        if (irq_req_i && ccr_reg[`CPUSR_CCR_I]) begin
            irq_ok = (irq_level_i < current_irq_level);
        end
    end

    // outputs registered one cycle after the state they mirror
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o                <= 32'h00000000;
            wb_ack_o                <= 1'b0;
            instr_address_counter_o <= `CPUSR_RST_WORD;
            acc_o                   <= `CPUSR_RST_WORD;
            tacc_o                  <= `CPUSR_RST_WORD;
            index_reg_o             <= `CPUSR_RST_WORD;
            extra_pointer_o         <= `CPUSR_RST_WORD;
            stack_pointer_o         <= `CPUSR_RST_WORD;
            program_status_word_o   <= `CPUSR_RST_PSW;
            greg_addr_o             <= 16'h0000;
            dir_phys_o              <= 16'h0000;
            irq_accept_o            <= 1'b0;
        end else begin
            wb_ack_o                <= wb_req;
            wb_dat_o                <= wb_req ? rd_next : 32'h00000000;
            instr_address_counter_o <= instr_address_counter_reg;
            acc_o                   <= acc_reg;
            tacc_o                  <= tacc_reg;
            index_reg_o             <= index_reg;
            extra_pointer_o         <= extra_pointer_reg;
            stack_pointer_o         <= stack_pointer_reg;
            program_status_word_o   <= {psw_hi_reg, ccr_reg};
            greg_addr_o             <= greg_addr;
            dir_phys_o              <= dir_phys;
            irq_accept_o            <= irq_ok;
        end
    end
endmodule

// *** design/cpusr_flag_alu.v ***
`timescale 1ns/10ps
`include "cpusr_regs.vh"
// 8/16-bit arithmetic that produces the result and the flag set
module cpusr_flag_alu (
    input  wire [2:0]  op_i,
    input  wire        wide_i,
    input  wire [15:0] a_i,
    input  wire [15:0] b_i,
    input  wire        carry_i,
    output reg  [15:0] res_o,
    output reg         h_o,
    output reg         n_o,
    output reg         z_o,
    output reg         v_o,
    output reg         c_o
);
    reg [16:0] sum;
    reg [4:0]  nib;
    reg        msb_a;
    reg        msb_b;
    reg        msb_r;
    always @* begin
        sum   = 17'h00000;
        nib   = 5'h00;
        res_o = 16'h0000;
        c_o   = 1'b0;
        case (op_i)
            `CPUSR_OP_ADD: begin
                sum = {1'b0, a_i} + {1'b0, b_i};
                nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
            end
            `CPUSR_OP_SUB: begin
                sum = {1'b0, a_i} - {1'b0, b_i};
                nib = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]};
            end
            `CPUSR_OP_SHL: sum = {1'b0, a_i[14:0], 1'b0};
            // an 8-bit shift must not pull bit 8 into the low byte
            `CPUSR_OP_SHR: sum = wide_i ? {2'b00, a_i[15:1]}
                                        : {10'h000, a_i[7:1]};
            default:       sum = {1'b0, a_i};
        endcase
        // only the low byte takes part in 8-bit work
        res_o = wide_i ? sum[15:0] : {8'h00, sum[7:0]};
        case (op_i)
            `CPUSR_OP_ADD,
            `CPUSR_OP_SUB: c_o = wide_i ? sum[16]
                               : (sum[8] ^ a_i[8] ^ b_i[8]);
            `CPUSR_OP_SHL: c_o = wide_i ? a_i[15] : a_i[7];
            `CPUSR_OP_SHR: c_o = a_i[0];
            default:       c_o = carry_i;
        endcase
        msb_a = wide_i ? a_i[15] : a_i[7];
        msb_b = wide_i ? b_i[15] : b_i[7];
        msb_r = wide_i ? res_o[15] : res_o[7];
        h_o = nib[4];
        n_o = msb_r;
        z_o = (res_o == 16'h0000);
        case (op_i)
            `CPUSR_OP_ADD: v_o = (msb_a == msb_b) && (msb_r != msb_a);
            `CPUSR_OP_SUB: v_o = (msb_a != msb_b) && (msb_r != msb_a);
            default:       v_o = 1'b0;
        endcase
    end
endmodule

// *** design/cpusr_regs.vh ***
`ifndef CPUSR_REGS_VH
`define CPUSR_REGS_VH
// wishbone word offsets (byte addresses)
`define CPUSR_OFF_PC        6'h00
`define CPUSR_OFF_ACC       6'h04
`define CPUSR_OFF_TACC      6'h08
`define CPUSR_OFF_IX        6'h0c
`define CPUSR_OFF_EP        6'h10
`define CPUSR_OFF_SP        6'h14
`define CPUSR_OFF_PSW       6'h18
`define CPUSR_OFF_MIRROR    6'h1c
`define CPUSR_OFF_STATUS    6'h20
// psw field positions
`define CPUSR_PSW_BANK_HI   15
`define CPUSR_PSW_BANK_LO   11
`define CPUSR_PSW_PAGE_HI   10
`define CPUSR_PSW_PAGE_LO   8
`define CPUSR_CCR_H         7
`define CPUSR_CCR_I         6
`define CPUSR_CCR_IL_HI     5
`define CPUSR_CCR_IL_LO     4
`define CPUSR_CCR_N         3
`define CPUSR_CCR_Z         2
`define CPUSR_CCR_V         1
`define CPUSR_CCR_C         0
// reset values
`define CPUSR_RST_WORD      16'h0000
`define CPUSR_RST_PSW       16'h0030
// memory map constants
`define CPUSR_GREG_HIGH     8'h01
`define CPUSR_MIRROR_ADDR   16'h0078
`define CPUSR_DIR_PAGE_BASE 16'h0080
`define CPUSR_IL_NONE       2'h3
// alu operation codes
`define CPUSR_OP_ADD        3'h0
`define CPUSR_OP_SUB        3'h1
`define CPUSR_OP_SHL        3'h2
`define CPUSR_OP_SHR        3'h3
`define CPUSR_OP_PASS       3'h4
`endif

// *** dv/cpusr_core_regs_assertions.sv ***
`timescale 1ns/10ps
module cpusr_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire        wb_ack_o,
    input wire        sp_load_i,
    input wire [15:0] load_val_i,
    input wire [2:0]  reg_sel_i,
    input wire [7:0]  dir_addr_i,
    input wire        irq_req_i,
    input wire [1:0]  irq_level_i,
    input wire [15:0] stack_pointer_o,
    input wire [15:0] program_status_word_o,
    input wire [15:0] greg_addr_o,
    input wire [15:0] dir_phys_o,
    input wire        irq_accept_o
);
    logic [1:0] up_reg;
    wire        ok = (up_reg == 2'h3);
    // outputs read as zero for one edge after reset, so wait before comparing
    always @(posedge clk_i) begin
        if (rst_i)
            up_reg <= 2'h0;
        else if (!ok)
            up_reg <= up_reg + 2'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_resp: assert property (s_req |=> s_pulse)
        else $error("ack pulse missing after request");
    a_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without a cycle");
    a_sp_load: assert property (
        sp_load_i && !wb_cyc_i |-> ##2 stack_pointer_o == $past(load_val_i, 2))
        else $error("stack pointer load lost");
    a_sp_hold: assert property (
        !sp_load_i && !wb_cyc_i |-> ##2 $stable(stack_pointer_o))
        else $error("stack pointer changed unasked");
    a_psw_reset: assert property (
        $fell(rst_i) |-> program_status_word_o == 16'h0030)
        else $error("status word reset value wrong");
    a_greg_form: assert property (ok |=> greg_addr_o[15:8] == 8'h01 &&
        greg_addr_o[2:0] == $past(reg_sel_i) &&
        greg_addr_o[7:3] == program_status_word_o[15:11])
        else $error("register address malformed");
    a_dir_low: assert property (ok && !dir_addr_i[7] |=>
        dir_phys_o == {8'h00, $past(dir_addr_i)})
        else $error("low direct address remapped");
    a_irq_gate: assert property (ok |-> irq_accept_o ==
        (program_status_word_o[6] && $past(irq_req_i) &&
        $past(irq_level_i) < program_status_word_o[5:4]))
        else $error("interrupt acceptance wrong");
endmodule
bind cpusr_core_regs cpusr_chk chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .sp_load_i(sp_load_i),
    .load_val_i(load_val_i), .reg_sel_i(reg_sel_i), .dir_addr_i(dir_addr_i),
    .irq_req_i(irq_req_i), .irq_level_i(irq_level_i),
    .stack_pointer_o(stack_pointer_o),
    .program_status_word_o(program_status_word_o),
    .greg_addr_o(greg_addr_o), .dir_phys_o(dir_phys_o),
    .irq_accept_o(irq_accept_o));

// *** dv/cpusr_seq_model.sv ***
`timescale 1ns/10ps
// sequencer stand-in: one request becomes a one-cycle strobe with its value
module cpusr_seq_model (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         go_i,
    input  wire  [3:0]  kind_i,
    input  wire  [15:0] val_i,
    output logic [11:0] strb_o,
    output logic [15:0] val_o
);
    always @(posedge clk_i) begin
        if (rst_i) begin
            strb_o <= 12'h000;
            val_o  <= 16'h0000;
        end else if (go_i) begin
            strb_o <= 12'h001 << kind_i;
            val_o  <= val_i;
        end else begin
            strb_o <= 12'h000;
            // value is meaningless without a strobe, so keep it moving
            val_o  <= ~val_o;
        end
    end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic        go = 0, wide = 0, irq = 0;
    logic [5:0]  adr = 0;
    logic [3:0]  sel = 0, kind = 0;
    logic [31:0] dat = 0;
    logic [15:0] gval = 0, maddr = 0;
    logic [2:0]  op = 0, rsel = 0;
    logic [7:0]  dira = 0;
    logic [1:0]  lvl = 0;
    wire  [31:0] rdat;
    wire  [15:0] pc, acc, tacc, ix, ep, sp, psw, ga, dp, sv;
    wire  [11:0] st;
    wire         ack, grant;
    wire  [5:0][15:0] outs = {sp, ep, ix, tacc, acc, pc};
    int          n_fail = 0, check_count = 0;
    always #5 clk_i = ~clk_i;
    cpusr_seq_model seq_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .kind_i(kind), .val_i(gval), .strb_o(st), .val_o(sv));
    cpusr_core_regs dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pc_load_i(st[0]),
        .pc_inc_i(st[1]), .pc_val_i(sv), .acc_load_i(st[2]),
        .tacc_load_i(st[3]), .acc_to_tacc_i(st[4]), .ix_load_i(st[5]),
        .ep_load_i(st[6]), .sp_load_i(st[7]), .load_val_i(sv),
        .alu_go_i(st[8]), .alu_op_i(op), .alu_wide_i(wide),
        .ps_hi_load_i(st[9]), .ccr_load_i(st[10]), .ps_val_i(sv[7:0]),
        .mem_wr_i(st[11]), .mem_addr_i(maddr), .mem_wdata_i(sv[7:0]),
        .reg_sel_i(rsel), .dir_addr_i(dira), .irq_req_i(irq),
        .irq_level_i(lvl), .instr_address_counter_o(pc), .acc_o(acc),
        .tacc_o(tacc), .index_reg_o(ix), .extra_pointer_o(ep),
        .stack_pointer_o(sp), .program_status_word_o(psw),
        .greg_addr_o(ga), .dir_phys_o(dp), .irq_accept_o(grant));
    task summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [5:0] a, input logic [3:0] s,
            input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            summarize();
        end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task seq(input logic [3:0] k, input logic [15:0] v);
        @(posedge clk_i);
        {go, kind, gval} <= {1'b1, k, v};
        @(posedge clk_i);
        go <= 0;
        repeat (4) @(posedge clk_i);
    endtask
    initial begin
        int i, j;
        int km[6] = '{0, 2, 3, 5, 6, 7};
        logic [31:0] q;
        logic [15:0] e, m[6], xp;
        logic [7:0] a8, b8;
        logic [8:0] r9;
        logic [4:0] bk;
        logic h, v;
        q = $urandom(32'h5d76);
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        for (i = 0; i < 10; i++) if (i != 8) begin
            wb(0, 6'(i * 4), 4'hf, 0, q);
            chk(q, (i == 6) ? 32'h30 : 32'h0);
        end
        $display("reset test done");
        for (i = 0; i < 6; i++) begin
            e = 16'($urandom);
            wb(1, 6'(i * 4), 4'h3, {16'($urandom), e}, q);
            // the output copy trails the register by one edge
            @(posedge clk_i);
            chk(outs[i], e);
            e[15:8] = 8'($urandom);
            wb(1, 6'(i * 4), 4'h2, {16'h0, e[15:8], 8'h5a}, q);
            wb(0, 6'(i * 4), 4'hf, 0, q);
            chk(q, {16'h0, e});
            e = 16'($urandom);
            seq(4'(km[i]), e);
            m[i] = e;
            chk(outs[i], e);
        end
        seq(1, 0);
        chk(pc, m[0] + 16'h1);
        seq(4, 0);
        chk(tacc, m[1]);
        $display("register test done");
        for (j = 0; j < 12; j++) begin
            a8 = (j == 0) ? 8'h80 : 8'($urandom);
            b8 = (j == 0) ? 8'h80 : 8'($urandom);
            wb(1, 6'h04, 4'h3, {16'h0, 8'($urandom), a8}, q);
            wb(1, 6'h08, 4'h3, {16'h0, 8'($urandom), b8}, q);
            seq(10, 16'h0030);
            op <= 3'(j % 4);
            seq(8, 0);
            h = 0;
            v = 0;
            case (j % 4)
                0: begin
                    r9 = a8 + b8;
                    h = (a8[3:0] + b8[3:0]) > 15;
                    v = (a8[7] == b8[7]) && (r9[7] != a8[7]);
                end
                1: begin
                    r9 = {1'b0, a8} - {1'b0, b8};
                    h = a8[3:0] < b8[3:0];
                    v = (a8[7] != b8[7]) && (r9[7] != a8[7]);
                end
                2: r9 = {a8, 1'b0};
                default: r9 = {a8[0], 1'b0, a8[7:1]};
            endcase
            chk(acc, {8'h0, r9[7:0]});
            chk({(j % 4 > 1) ? 1'b0 : psw[7], psw[6:0]},
                {h, 3'b011, r9[7], r9[7:0] == 0, v, r9[8]});
        end
        wide <= 1;
        op <= 0;
        e = 16'($urandom);
        xp = 16'($urandom);
        wb(1, 6'h04, 4'h3, {16'h0, e}, q);
        wb(1, 6'h08, 4'h3, {16'h0, xp}, q);
        seq(8, 0);
        chk(acc, 16'(e + xp));
        wide <= 0;
        $display("flag test done");
        maddr <= 16'h0078;
        for (i = 0; i < 8; i++) begin
            bk = 5'($urandom);
            rsel <= 3'($urandom);
            dira <= 8'($urandom);
            seq(9, {8'h0, bk, 3'(i)});
            xp = (!dira[7] || i == 0) ? {8'h0, dira} :
                16'h0100 + 16'(i - 1) * 16'h80 + dira[6:0];
            chk(dp, xp);
            chk(ga, {8'h01, bk, rsel});
            chk(psw[15:8], {bk, 3'(i)});
            wb(0, 6'h1c, 4'hf, 0, q);
            chk(q, {bk, 3'(i)});
            wb(0, 6'h20, 4'hf, 0, q);
            chk(q, {8'h01, bk, rsel, xp});
        end
        e = 16'($urandom);
        wb(1, 6'h1c, 4'h1, {24'h0, e[7:0]}, q);
        wb(0, 6'h18, 4'hf, 0, q);
        chk(q[15:8], e[7:0]);
        seq(11, 16'h00a5);
        chk(psw[15:8], 8'ha5);
        maddr <= 16'h0079;
        seq(11, 16'h005a);
        chk(psw[15:8], 8'ha5);
        $display("address test done");
        irq <= 1;
        for (j = 0; j < 32; j++) begin
            lvl <= 2'(j >> 2);
            seq(10, {9'h0, j[4], j[1:0], 4'h0});
            chk(grant, j[4] && j[3:2] < j[1:0]);
        end
        irq <= 0;
        seq(10, 16'h0070);
        chk(grant, 0);
        $display("interrupt test done");
        summarize();
    end
endmodule
